// >>> logic/cal_rom_pkg.sv
// Package: address map, field layout and defaults of the factory calibration store.
// Assumes 14-bit program-memory words and byte-free word addressing.
package cal_rom_pkg;

	localparam int          ADDR_W   = 14;
	localparam int          WORD_W   = 14;
	localparam int          NUM_WORDS = 16;

	localparam logic [13:0] CAL_BASE = 14'h2080;
	localparam logic [13:0] CAL_LAST = 14'h208F;

	localparam logic [13:0] AMP_OFFSET_INTERNAL_FB_WORD     = 14'h2080;
	localparam logic [13:0] DESAT_AND_RESISTOR_TRIM_WORD    = 14'h2081;
	localparam logic [13:0] REFERENCE_AND_BANDGAP_TRIM_WORD = 14'h2082;
	localparam logic [13:0] OVERTEMP_THRESHOLD_TRIM_WORD    = 14'h2083;
	localparam logic [13:0] TEMP_SENSOR_REFERENCE_WORD      = 14'h2084;
	localparam logic [13:0] OSCILLATOR_TRIM_WORD            = 14'h2085;
	localparam logic [13:0] AMP_OFFSET_EXTERNAL_OUT_WORD    = 14'h2086;

	// Implemented-bit masks per word
	localparam logic [13:0] MASK_W1 = 14'h007F;
	localparam logic [13:0] MASK_W2 = 14'h1F3F;
	localparam logic [13:0] MASK_W3 = 14'h3F0F;
	localparam logic [13:0] MASK_W4 = 14'h000F;
	localparam logic [13:0] MASK_W5 = 14'h03FF;
	localparam logic [13:0] MASK_W6 = 14'h007F;
	localparam logic [13:0] MASK_W7 = 14'h007F;

	// Field positions
	localparam int DESAT_LSB   = 8;
	localparam int DESAT_W     = 5;
	localparam int FB_RES_LSB  = 0;
	localparam int FB_RES_W    = 6;
	localparam int VREF_LSB    = 8;
	localparam int VREF_W      = 6;
	localparam int BG_LSB      = 0;
	localparam int BG_W        = 4;
	localparam int OT_W        = 4;
	localparam int AMP_W       = 7;
	localparam int OSC_W       = 7;
	localparam int FB_SEL_BIT  = 5;

	// Unprogrammed flash reads all ones; masking leaves implemented bits at one
	localparam logic [13:0] ERASED_WORD = 14'h3FFF;

	// Mode register value after reset
	localparam logic [7:0]  MODE_RESET  = 8'h00;

	// Trim loader index after reset
	localparam logic [3:0]  LOAD_IDX_RESET = 4'h0;

endpackage // cal_rom_pkg

// >>> logic/cal_rom_if.sv
// Interface: program-memory read and write path between firmware and calibration store.
// Assumes one clock shared by both ends.
interface cal_rom_if (
	input wire logic clk
);
	logic [13:0] addr;
	logic        rd;
	logic        wr;
	logic [13:0] wdata;
	logic [13:0] rdata;

	modport dev (
		input  addr,
		input  rd,
		input  wr,
		input  wdata,
		output rdata
	);

	modport fw (
		output addr,
		output rd,
		output wr,
		output wdata,
		input  rdata
	);
endinterface // cal_rom_if

// >>> logic/cal_word_mask.sv
// Module: combinational mask that forces unimplemented calibration bits to zero.
// Assumes an address already inside the calibration range.
module cal_word_mask (
	input  wire logic [13:0] addr,
	input  wire logic [13:0] raw,
	output logic      [13:0] word
);
	function automatic logic [13:0] mask_for(input logic [13:0] a);
		case (a)
			cal_rom_pkg::AMP_OFFSET_INTERNAL_FB_WORD:     mask_for = cal_rom_pkg::MASK_W1;
			cal_rom_pkg::DESAT_AND_RESISTOR_TRIM_WORD:    mask_for = cal_rom_pkg::MASK_W2;
			cal_rom_pkg::REFERENCE_AND_BANDGAP_TRIM_WORD: mask_for = cal_rom_pkg::MASK_W3;
			cal_rom_pkg::OVERTEMP_THRESHOLD_TRIM_WORD:    mask_for = cal_rom_pkg::MASK_W4;
			cal_rom_pkg::TEMP_SENSOR_REFERENCE_WORD:      mask_for = cal_rom_pkg::MASK_W5;
			cal_rom_pkg::OSCILLATOR_TRIM_WORD:            mask_for = cal_rom_pkg::MASK_W6;
			cal_rom_pkg::AMP_OFFSET_EXTERNAL_OUT_WORD:    mask_for = cal_rom_pkg::MASK_W7;
			// Words beyond the seventh are outside this block and pass unmasked
			default:                                      mask_for = 14'h3FFF;
		endcase
	endfunction

	always_comb begin
		word = raw & mask_for(addr);
	end
endmodule // cal_word_mask

// >>> logic/cal_rom_dev.sv
// Functional notes
// - Calibration range is read-only, returns factory data
// - Word 1: amplifier offset, internal feedback, 7 bits
// - Amplifier offset codes 20h and 00h mean zero
// - Firmware loads word 1 into amplifier offset register
// - Word 2: desaturation offset and resistor trim
// - Desaturation offset is sign-magnitude, two zero codes
// - Firmware copies or overrides desaturation offset
// - Firmware copies resistor trim into its register
// - Word 3: reference buffer and bandgap trims
// - Firmware copies reference and bandgap trims
// - Word 4: overtemperature threshold trim, 4 bits
// - Firmware copies overtemperature threshold trim
// - Word 5: temperature sensor reading at 30 C
// - Word 6: oscillator trim, 7 bits
// - Firmware copies oscillator trim
// - Word 7: amplifier offset, external output, 7 bits
// - External output uses word 7 instead of 1
// - Mode bit 5 selects amplifier feedback path
//
// Device end: factory calibration store behind the program-memory read path.
// Assumes factory contents arrive as parameters and reads answer one cycle later.
module cal_rom_dev #(
	parameter logic [13:0] FACTORY_W1 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W2 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W3 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W4 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W5 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W6 = cal_rom_pkg::ERASED_WORD,
	parameter logic [13:0] FACTORY_W7 = cal_rom_pkg::ERASED_WORD
) (
	input wire logic clk,
	input wire logic resetn,
	cal_rom_if.dev   bus,
	output logic     in_range_hit
);
	typedef struct packed {
		logic [13:0] rdata;
		logic        hit;
	} dev_state_t;

	dev_state_t  q;
	dev_state_t  d;
	logic [13:0] raw;
	logic [13:0] masked;
	logic        in_range;

	// =====================================================================
	// Factory content
	// Contents are constants: nothing in this module can alter them.
	always_comb begin
		case (bus.addr)
			cal_rom_pkg::AMP_OFFSET_INTERNAL_FB_WORD:     raw = FACTORY_W1;
			cal_rom_pkg::DESAT_AND_RESISTOR_TRIM_WORD:    raw = FACTORY_W2;
			cal_rom_pkg::REFERENCE_AND_BANDGAP_TRIM_WORD: raw = FACTORY_W3;
			cal_rom_pkg::OVERTEMP_THRESHOLD_TRIM_WORD:    raw = FACTORY_W4;
			cal_rom_pkg::TEMP_SENSOR_REFERENCE_WORD:      raw = FACTORY_W5;
			cal_rom_pkg::OSCILLATOR_TRIM_WORD:            raw = FACTORY_W6;
			cal_rom_pkg::AMP_OFFSET_EXTERNAL_OUT_WORD:    raw = FACTORY_W7;
			default:                                      raw = cal_rom_pkg::ERASED_WORD;
		endcase
	end

	cal_word_mask u_mask (
		.addr (bus.addr),
		.raw  (raw),
		.word (masked)
	);

	assign in_range = (bus.addr >= cal_rom_pkg::CAL_BASE) && (bus.addr <= cal_rom_pkg::CAL_LAST);

	// =====================================================================
	// Read path
	always_comb begin
		d = q;
		d.hit = 1'b0;
		if (bus.rd) begin
			d.rdata = in_range ? masked : 14'h0000;
			d.hit   = in_range;
		end
		// A write leaves contents and read data untouched
		if (bus.wr) begin
			d.hit = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.rdata    = q.rdata;
	assign in_range_hit = q.hit;
endmodule // cal_rom_dev

// >>> logic/cal_trim_loader.sv
// Firmware end: on start, reads calibration words and loads the trim registers.
// Assumes the device answers a read with data one cycle later.
module cal_trim_loader (
	input  wire logic       clk,
	input  wire logic       resetn,
	cal_rom_if.fw           bus,
	input  wire logic       start,
	input  wire logic       mode_wr,
	input  wire logic [7:0] mode_wdata,
	input  wire logic       desat_user_en,
	input  wire logic [4:0] desat_user_val,
	output logic      [7:0] mode_and_feedback_register,
	output logic      [6:0] amp_offset_cal_register,
	output logic      [4:0] desat_offset_cal_register,
	output logic      [5:0] feedback_resistor_cal_register,
	output logic      [5:0] reference_buffer_cal_register,
	output logic      [3:0] bandgap_cal_register,
	output logic      [3:0] overtemp_threshold_cal_register,
	output logic      [6:0] oscillator_cal_register,
	output logic      [9:0] temp_sensor_reference_reading,
	output logic            feedback_path_select,
	output logic            done
);
	typedef enum logic [1:0] {IDLE, ISSUE, CAPTURE, FINISH} load_st_t;

	typedef struct packed {
		load_st_t    st;
		logic [13:0] addr;
		logic        rd;
		logic [7:0]  mode;
		logic [6:0]  amp;
		logic [4:0]  desat;
		logic [5:0]  fb_res;
		logic [5:0]  vref;
		logic [3:0]  bg;
		logic [3:0]  ot;
		logic [6:0]  osc;
		logic [9:0]  temp;
		logic        done;
	} fw_state_t;

	fw_state_t q;
	fw_state_t d;

	always_comb begin
		d    = q;
		d.rd = 1'b0;
		if (mode_wr) begin
			d.mode = mode_wdata;
		end
		case (q.st)
			IDLE: begin
				if (start) begin
					d.st   = ISSUE;
					d.done = 1'b0;
					// Pick the offset word matching the active feedback path
					d.addr = d.mode[cal_rom_pkg::FB_SEL_BIT] ?
						cal_rom_pkg::AMP_OFFSET_EXTERNAL_OUT_WORD :
						cal_rom_pkg::AMP_OFFSET_INTERNAL_FB_WORD;
				end
			end
			ISSUE: begin
				d.rd = 1'b1;
				d.st = CAPTURE;
			end
			CAPTURE: begin
				// Data for the read issued last cycle stands now
				if (!q.rd) begin
					case (q.addr)
						cal_rom_pkg::AMP_OFFSET_INTERNAL_FB_WORD,
						cal_rom_pkg::AMP_OFFSET_EXTERNAL_OUT_WORD: begin
							d.amp  = bus.rdata[6:0];
							d.addr = cal_rom_pkg::DESAT_AND_RESISTOR_TRIM_WORD;
						end
						cal_rom_pkg::DESAT_AND_RESISTOR_TRIM_WORD: begin
							d.desat = desat_user_en ? desat_user_val :
								bus.rdata[12:8];
							d.fb_res = bus.rdata[5:0];
							d.addr = cal_rom_pkg::REFERENCE_AND_BANDGAP_TRIM_WORD;
						end
						cal_rom_pkg::REFERENCE_AND_BANDGAP_TRIM_WORD: begin
							d.vref = bus.rdata[13:8];
							d.bg   = bus.rdata[3:0];
							d.addr = cal_rom_pkg::OVERTEMP_THRESHOLD_TRIM_WORD;
						end
						cal_rom_pkg::OVERTEMP_THRESHOLD_TRIM_WORD: begin
							d.ot   = bus.rdata[3:0];
							d.addr = cal_rom_pkg::TEMP_SENSOR_REFERENCE_WORD;
						end
						cal_rom_pkg::TEMP_SENSOR_REFERENCE_WORD: begin
							d.temp = bus.rdata[9:0];
							d.addr = cal_rom_pkg::OSCILLATOR_TRIM_WORD;
						end
						default: begin
							d.osc = bus.rdata[6:0];
						end
					endcase
					d.st = (q.addr == cal_rom_pkg::OSCILLATOR_TRIM_WORD) ? FINISH : ISSUE;
				end
			end
			FINISH: begin
				d.done = 1'b1;
				d.st   = IDLE;
			end
			default: d.st = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q      <= '0;
			q.st   <= IDLE;
			q.mode <= cal_rom_pkg::MODE_RESET;
			q.addr <= cal_rom_pkg::AMP_OFFSET_INTERNAL_FB_WORD;
		end else begin
			q <= d;
		end
	end

	assign bus.addr  = q.addr;
	assign bus.rd    = q.rd;
	assign bus.wr    = 1'b0;
	assign bus.wdata = 14'h0000;

	assign mode_and_feedback_register      = q.mode;
	assign amp_offset_cal_register         = q.amp;
	assign desat_offset_cal_register       = q.desat;
	assign feedback_resistor_cal_register  = q.fb_res;
	assign reference_buffer_cal_register   = q.vref;
	assign bandgap_cal_register            = q.bg;
	assign overtemp_threshold_cal_register = q.ot;
	assign oscillator_cal_register         = q.osc;
	assign temp_sensor_reference_reading   = q.temp;
	assign feedback_path_select            = q.mode[cal_rom_pkg::FB_SEL_BIT];
	assign done                            = q.done;
endmodule // cal_trim_loader

// >>> verif/cal_rom_assertions.sv
// Checker: read-path properties of the bus joining the trim loader and the store.
// Assumes one clock, an async active-low reset and the loader as the only master.
module cal_rom_assertions (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [13:0] addr,
	input wire logic        rd,
	input wire logic        wr,
	input wire logic [13:0] wdata,
	input wire logic [13:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Unused bits of each word read zero
	chk_w1_zero_bits: assert property (
		rd && addr == 14'h2080 |=> (rdata & 14'h3F80) == 14'h0000) else $error("word 1 unused set");
	chk_w2_zero_bits: assert property (
		rd && addr == 14'h2081 |=> (rdata & 14'h20C0) == 14'h0000) else $error("word 2 unused set");
	chk_w3_zero_bits: assert property (
		rd && addr == 14'h2082 |=> (rdata & 14'h00F0) == 14'h0000) else $error("word 3 unused set");
	chk_w4_zero_bits: assert property (
		rd && addr == 14'h2083 |=> (rdata & 14'h3FF0) == 14'h0000) else $error("word 4 unused set");
	chk_w5_zero_bits: assert property (
		rd && addr == 14'h2084 |=> (rdata & 14'h3C00) == 14'h0000) else $error("word 5 unused set");
	chk_w6_zero_bits: assert property (
		rd && addr == 14'h2085 |=> (rdata & 14'h3F80) == 14'h0000) else $error("word 6 unused set");
	chk_w7_zero_bits: assert property (
		rd && addr == 14'h2086 |=> (rdata & 14'h3F80) == 14'h0000) else $error("word 7 unused set");
	// ==========================================================
	// Read data only moves after a read; loader stays inside the store
	chk_data_holds: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
	chk_loader_range: assert property (
		rd |-> addr >= 14'h2080 && addr <= 14'h2086 && !wr) else $error("loader read off range");
	chk_write_quiet: assert property (
		!wr && wdata == 14'h0000) else $error("loader drove a write");
	cover property (rd && addr == 14'h2080);
	cover property (rd && addr == 14'h2086);
	cover property (rd && addr == 14'h2085);
endmodule // cal_rom_assertions

// >>> verif/testbench.sv
// Testbench: store and loader face each other; a second store is driven directly.
// Assumes the loader reads six words after start and raises done, holding it until the next start.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [13:0] F1 = 14'h3FA0;
	localparam logic [13:0] F2 = 14'h30EA;
	localparam logic [13:0] F3 = 14'h2ABC;
	localparam logic [13:0] F4 = 14'h3FF5;
	localparam logic [13:0] F5 = 14'h3D5A;
	localparam logic [13:0] F6 = 14'h1FC3;
	localparam logic [13:0] F7 = 14'h3F9F;
	logic       clk, resetn, start, mode_wr, desat_user_en, hit, fps, done;
	logic [7:0] mode_wdata, mode_q;
	logic [4:0] desat_user_val, desat;
	logic [6:0] amp, osc;
	logic [5:0] fb_res, vref;
	logic [3:0] bg, ot;
	logic [9:0] temp;
	int         mismatches, comparisons, cycles, seed;
	cal_rom_if bus_a (.clk(clk));
	cal_rom_if bus_b (.clk(clk));
	cal_rom_dev #(.FACTORY_W1(F1), .FACTORY_W2(F2), .FACTORY_W3(F3), .FACTORY_W4(F4),
		.FACTORY_W5(F5), .FACTORY_W6(F6), .FACTORY_W7(F7)) u_cal_rom_dev (
		.clk(clk), .resetn(resetn), .bus(bus_a), .in_range_hit());
	cal_rom_dev #(.FACTORY_W1(F1), .FACTORY_W2(F2), .FACTORY_W3(F3), .FACTORY_W4(F4),
		.FACTORY_W5(F5), .FACTORY_W6(F6), .FACTORY_W7(F7)) u_cal_rom_dev_b (
		.clk(clk), .resetn(resetn), .bus(bus_b), .in_range_hit(hit));
	cal_trim_loader u_cal_trim_loader (.clk(clk), .resetn(resetn), .bus(bus_a), .start(start),
		.mode_wr(mode_wr), .mode_wdata(mode_wdata), .desat_user_en(desat_user_en),
		.desat_user_val(desat_user_val), .mode_and_feedback_register(mode_q),
		.amp_offset_cal_register(amp), .desat_offset_cal_register(desat),
		.feedback_resistor_cal_register(fb_res), .reference_buffer_cal_register(vref),
		.bandgap_cal_register(bg), .overtemp_threshold_cal_register(ot),
		.oscillator_cal_register(osc), .temp_sensor_reference_reading(temp),
		.feedback_path_select(fps), .done(done));
	cal_rom_assertions u_cal_rom_assertions (.clk(clk), .resetn(resetn), .addr(bus_a.addr),
		.rd(bus_a.rd), .wr(bus_a.wr), .wdata(bus_a.wdata), .rdata(bus_a.rdata));
	// ==========================================================
	function automatic logic [13:0] exp_word(input logic [13:0] a);
		case (a)
			14'h2080: return F1 & 14'h007F;
			14'h2081: return F2 & 14'h1F3F;
			14'h2082: return F3 & 14'h3F0F;
			14'h2083: return F4 & 14'h000F;
			14'h2084: return F5 & 14'h03FF;
			14'h2085: return F6 & 14'h007F;
			14'h2086: return F7 & 14'h007F;
			default: return (a > 14'h2086 && a <= 14'h208F) ? 14'h3FFF : 14'h0000;
		endcase
	endfunction
	task check(input string name, input logic [13:0] got, input logic [13:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task access_b(input logic [13:0] a, input logic w, input logic [13:0] d);
		@(posedge clk);
		bus_b.addr <= a;
		bus_b.wdata <= d;
		bus_b.wr <= w;
		bus_b.rd <= !w;
		@(posedge clk);
		bus_b.wr <= 1'b0;
		bus_b.rd <= 1'b0;
		#1;
	endtask
	// Mode write, then one load; the user desat value stays level through it
	task run_load(input logic fb, input logic en);
		logic [7:0] m;
		int         i;
		m = 8'($urandom);
		m[5] = fb;
		@(posedge clk);
		mode_wr <= 1'b1;
		mode_wdata <= m;
		desat_user_en <= en;
		desat_user_val <= 5'($urandom);
		@(posedge clk);
		mode_wr <= 1'b0;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		// Done is a level held from the last load until start is taken: look past that edge
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (done !== 1'b1 && i < 60);
		check("done", {13'h0, done}, 14'h0001);
		@(posedge clk);
		#1;
		check("fb select", {13'h0, fps}, {13'h0, fb});
		check("mode bit", {13'h0, mode_q[5]}, {13'h0, fb});
		check("amp offset", {7'h0, amp}, fb ? {7'h0, F7[6:0]} : {7'h0, F1[6:0]});
		check("desat", {9'h0, desat}, {9'h0, en ? desat_user_val : F2[12:8]});
		check("resistor", {8'h0, fb_res}, {8'h0, F2[5:0]});
		check("ref buffer", {8'h0, vref}, {8'h0, F3[13:8]});
		check("bandgap", {10'h0, bg}, {10'h0, F3[3:0]});
		check("overtemp", {10'h0, ot}, {10'h0, F4[3:0]});
		check("oscillator", {7'h0, osc}, {7'h0, F6[6:0]});
		check("temp ref", {4'h0, temp}, {4'h0, F5[9:0]});
	endtask
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		{resetn, start, mode_wr, desat_user_en, mode_wdata, desat_user_val} = '0;
		{bus_b.addr, bus_b.rd, bus_b.wr, bus_b.wdata} = '0;
		seed = $urandom(85463);
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		#1;
		check("amp after reset", {7'h0, amp}, 14'h0000);
		check("mode after reset", {6'h0, mode_q}, 14'h0000);
		// Write garbage first so an accepted write would show in the read-back
		for (int k = 0; k < 18; k++) begin
			access_b(14'h207F + 14'(k), 1'b1, 14'($urandom));
			access_b(14'h207F + 14'(k), 1'b0, 14'h0000);
			check("word", bus_b.rdata, exp_word(14'h207F + 14'(k)));
			check("hit", {13'h0, hit}, {13'h0, k > 0 && k < 17});
		end
		$display("test store map done");
		for (int k = 0; k < 4; k++) begin
			run_load(k[0], k[1]);
		end
		$display("test trim load done");
		summarize();
	end
endmodule // testbench
